// >>> rtl/floppy_cmd_regs.vh
/*
 Constants for the floppy command interpreter: status bit positions,
 phase byte counts, opcodes and timing figures.
 Assumes a 20 MHz system clock.
*/
`ifndef FLOPPY_CMD_REGS_VH
`define FLOPPY_CMD_REGS_VH

// ----------------------------------------
// Error status one bits
// ----------------------------------------
`define ES1_NO_SECTOR 2
`define ES1_WP_HIT 1
`define ES1_ABSENT_ID 0
// ----------------------------------------
// Error status two bits
// ----------------------------------------
`define ES2_DELETED 6
`define ES2_DATA_CRC 5
`define ES2_CYL_MISMATCH 4
`define ES2_SCAN_EQUAL 3
`define ES2_SCAN_UNMET 2
`define ES2_BAD_TRACK 1
`define ES2_NO_DATA_MARK 0
// ----------------------------------------
// Command sequence
// ----------------------------------------
`define CMD_BYTES 4'd9
`define RES_BYTES 3'd7
`define OP_READ_DATA 5'h06
`define OP_READ_DEL 5'h0c
`define OP_WRITE_DATA 5'h05
`define OP_WRITE_DEL 5'h09
`define OP_READ_DIAG 5'h02
`define OP_READ_ID 5'h0a
`define OP_FORMAT 5'h0d
`define OP_SENSE_DRIVE 5'h04
`define OP_SCAN_EQ 5'h11
`define OP_SCAN_LE 5'h19
`define OP_SCAN_HE 5'h1d
`define BAD_CYL 8'hff
`define ID_MISS_INDEX 2'd2
// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 20000000
`define SETTLE_STEP_MS 2
`define RELEASE_STEP_MS 16
`define STEP_UNIT_MS 1
`define CYC_PER_MS (`CLK_HZ / 1000)

`endif

// >>> rtl/floppy_cmd_status_logic.v
/*
 Command interpreter and result status logic of a floppy controller.
 Host side: register select, read and write strobes, 8-bit data in/out.
 Medium side: event pulses from an external read/write channel, which
 searches sectors and reports markers, header cylinder and CRC results.
*/
`timescale 1ns/1ps
`include "floppy_cmd_regs.vh"

// Summary of operation
// RULE_01: Sector not found, or bad ID read, or diagnostic start missing sets no-sector; the code sets it for the first two only.
// RULE_02: Write protect during write or format sets write-protect hit.
// RULE_03: No ID marker before two index pulses, or no data marker, sets absent-ID.
// RULE_04: Deleted marker in read/scan, or normal marker in read-deleted, sets deleted-seen.
// RULE_05: Data field CRC failure sets data CRC fault.
// RULE_06: Header cylinder differing from target cylinder sets cylinder mismatch.
// RULE_07: Mismatch with header cylinder all ones also sets bad-track.
// RULE_08: Scan equality met sets scan equal hit.
// RULE_09: Scan with no sector meeting condition sets scan unmet.
// RULE_10: Missing data or deleted data marker sets no-data-marker.
// RULE_11: Drive status shows fault, protect, ready, track zero, two-side, head, units.
// RULE_12: Each command runs command, execution, then result phase; specify stays in command phase and sense drive skips execution.
// RULE_13: Most commands take nine bytes and return seven result bytes.
// RULE_14: Select low reaches main status, high reaches data register.
// RULE_15: Settle time 2 to 254 ms in 2 ms; release 16 to 240 ms in 16 ms.
// RULE_16: Step interval 1 to 16 ms, code F is 1 ms, E is 2 ms.
// RULE_17: Density bit low selects FM, high selects MFM.
// RULE_18: Both-sides flag continues at sector 1 of side 1 after side 0.
// RULE_19: Transfer stops after the sector equal to the last-sector number.
// RULE_20: Gap length sets sync-low bytes after CRC, or gap 3 size in format.
// RULE_21: Scan step 1 compares contiguous sectors, 2 compares alternate ones.
// RULE_22: Four ID bytes are compared to each sector header.
// RULE_23: Host keeps select high for all data register transfers.
// RULE_24: Master request and direction bits pace every data transfer.
// RULE_25: Result bytes advance one per host read, then command phase resumes.
// RULE_26: Error flags clear at the start of each new command.
module floppy_cmd_status_logic #(
	parameter CLK_HZ = `CLK_HZ
)(
	input wire i_clk,
	input wire i_reset_n,
	input wire i_register_select_line,
	input wire i_rd_n,
	input wire i_wr_n,
	input wire [7:0] i_data,
	output reg [7:0] o_data,
	output reg o_data_oe,
	input wire i_drive_fault_state,
	input wire i_write_protect,
	input wire i_drive_ready_state,
	input wire i_track_zero_state,
	input wire i_two_sided_state,
	input wire i_index,
	input wire i_id_marker_seen,
	input wire i_header_valid,
	input wire [7:0] i_hdr_cyl,
	input wire [7:0] i_hdr_head,
	input wire [7:0] i_hdr_sector,
	input wire [7:0] i_hdr_size,
	input wire i_id_crc_fault,
	input wire i_data_marker_seen,
	input wire i_deleted_marker_seen,
	input wire i_data_mark_timeout,
	input wire i_data_crc_fault,
	input wire i_sector_done,
	input wire i_scan_equal,
	input wire i_scan_met,
	output reg o_exec_active,
	output reg o_head_select,
	output reg o_drive_unit_sel_low,
	output reg o_drive_unit_sel_high,
	output reg o_density_select,
	output reg [7:0] o_target_sector,
	output reg o_sector_match,
	output reg [7:0] o_gap_three_len,
	output reg [1:0] o_scan_step,
	output reg [23:0] o_settle_cycles,
	output reg [23:0] o_release_cycles,
	output reg [23:0] o_step_cycles
);

	localparam [31:0] CYC_MS = CLK_HZ / 1000;
	localparam [1:0] PH_CMD = 2'd0;
	localparam [1:0] PH_EXEC = 2'd1;
	localparam [1:0] PH_RES = 2'd2;

	reg [1:0] phase_reg;
	reg [3:0] cmd_cnt_reg;
	reg [2:0] res_cnt_reg;
	reg [4:0] opcode_reg;
	reg both_sides_flag_reg;
	reg [7:0] internal_target_reg [0:3];
	reg [7:0] last_sector_num_reg;
	reg [7:0] error_status_one_reg;
	reg [7:0] error_status_two_reg;
	reg [1:0] index_cnt_reg;
	reg scan_hit_any_reg;
	reg id_seen_reg;
	reg rd_d_reg;
	reg wr_d_reg;
	reg [7:0] result_byte;

	wire rd_edge = !i_rd_n && rd_d_reg;
	wire wr_edge = !i_wr_n && wr_d_reg;
	wire is_write = opcode_reg == `OP_WRITE_DATA || opcode_reg == `OP_WRITE_DEL || opcode_reg == `OP_FORMAT;
	wire is_scan = opcode_reg == `OP_SCAN_EQ || opcode_reg == `OP_SCAN_LE || opcode_reg == `OP_SCAN_HE;
	wire is_read = opcode_reg == `OP_READ_DATA || opcode_reg == `OP_READ_DEL || opcode_reg == `OP_READ_DIAG;
	wire cyl_differs = i_hdr_cyl != internal_target_reg[0];
	wire hdr_match = !cyl_differs && i_hdr_head == internal_target_reg[1]
		&& i_hdr_sector == internal_target_reg[2] && i_hdr_size == internal_target_reg[3]; // [RULE_22]
	wire [7:0] drive_signal_status = {i_drive_fault_state, i_write_protect, i_drive_ready_state,
		i_track_zero_state, i_two_sided_state, o_head_select, o_drive_unit_sel_high,
		o_drive_unit_sel_low}; // [RULE_11]
	wire [7:0] main_status = {phase_reg != PH_EXEC, phase_reg == PH_RES, o_exec_active,
		phase_reg != PH_CMD || cmd_cnt_reg != 4'd0, 4'h0}; // [RULE_24]
	// Products are formed at 32 bits and cut on purpose; the largest setting still fits in 24 bits
	wire [4:0] step_ms = 5'd16 - {1'b0, i_data[7:4]}; // [RULE_16]
	wire [31:0] step_prod = {27'h0000000, step_ms} * CYC_MS * `STEP_UNIT_MS;
	wire [31:0] release_prod = {28'h0000000, i_data[3:0]} * CYC_MS * `RELEASE_STEP_MS;
	wire [31:0] settle_prod = {25'h0000000, i_data[7:1]} * CYC_MS * `SETTLE_STEP_MS;

	// ----------------------------------------
	// Result byte selection
	// ----------------------------------------
	always @*
	begin
		case (res_cnt_reg)
			3'd0: result_byte = {6'h00, o_drive_unit_sel_high, o_drive_unit_sel_low} | {5'h00, o_head_select, 2'h0};
			3'd1: result_byte = error_status_one_reg;
			3'd2: result_byte = error_status_two_reg;
			3'd3: result_byte = internal_target_reg[0];
			3'd4: result_byte = internal_target_reg[1];
			3'd5: result_byte = internal_target_reg[2];
			3'd6: result_byte = internal_target_reg[3];
			default: result_byte = drive_signal_status;
		endcase
	end

	// ----------------------------------------
	// Host interface and phase sequencing
	// ----------------------------------------
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			phase_reg <= PH_CMD;
			cmd_cnt_reg <= 4'd0;
			res_cnt_reg <= 3'd0;
			opcode_reg <= 5'h00;
			both_sides_flag_reg <= 1'b0;
			internal_target_reg[0] <= 8'h00;
			internal_target_reg[1] <= 8'h00;
			internal_target_reg[2] <= 8'h00;
			internal_target_reg[3] <= 8'h00;
			last_sector_num_reg <= 8'h00;
			error_status_one_reg <= 8'h00;
			error_status_two_reg <= 8'h00;
			index_cnt_reg <= 2'd0;
			scan_hit_any_reg <= 1'b0;
			id_seen_reg <= 1'b0;
			rd_d_reg <= 1'b1;
			wr_d_reg <= 1'b1;
			o_data <= 8'h00;
			o_data_oe <= 1'b0;
			o_exec_active <= 1'b0;
			o_head_select <= 1'b0;
			o_drive_unit_sel_low <= 1'b0;
			o_drive_unit_sel_high <= 1'b0;
			o_density_select <= 1'b0;
			o_target_sector <= 8'h00;
			o_sector_match <= 1'b0;
			o_gap_three_len <= 8'h00;
			o_scan_step <= 2'd1;
			o_settle_cycles <= 24'h000000;
			o_release_cycles <= 24'h000000;
			o_step_cycles <= 24'h000000;
		end
		else
		begin
			rd_d_reg <= i_rd_n;
			wr_d_reg <= i_wr_n;
			o_data_oe <= !i_rd_n;
			o_data <= i_register_select_line ? result_byte : main_status; // [RULE_14]
			o_sector_match <= o_exec_active && i_header_valid && hdr_match;
			o_target_sector <= internal_target_reg[2];
			case (phase_reg)
				PH_CMD:
				begin
					if (wr_edge && i_register_select_line) // [RULE_23]
					begin
						cmd_cnt_reg <= cmd_cnt_reg + 4'd1;
						case (cmd_cnt_reg)
							4'd0:
							begin
								opcode_reg <= i_data[4:0];
								both_sides_flag_reg <= i_data[7];
								o_density_select <= i_data[6]; // [RULE_17]
								error_status_one_reg <= 8'h00; // [RULE_26]
								error_status_two_reg <= 8'h00;
								scan_hit_any_reg <= 1'b0;
								id_seen_reg <= 1'b0;
								index_cnt_reg <= 2'd0;
							end
							4'd1:
							begin
								o_head_select <= i_data[2];
								o_drive_unit_sel_high <= i_data[1];
								o_drive_unit_sel_low <= i_data[0];
								if (opcode_reg == 5'h03)
									o_step_cycles <= step_prod[23:0]; // [RULE_16]
								if (opcode_reg == 5'h03)
									o_release_cycles <= release_prod[23:0]; // [RULE_15]
							end
							4'd2: internal_target_reg[0] <= i_data;
							4'd3: internal_target_reg[1] <= i_data;
							4'd4: internal_target_reg[2] <= i_data;
							4'd5: internal_target_reg[3] <= i_data;
							4'd6: last_sector_num_reg <= i_data;
							4'd7: o_gap_three_len <= i_data; // [RULE_20]
							default:
							begin
								if (is_scan)
									o_scan_step <= i_data[1:0]; // [RULE_21]
							end
						endcase
						if (opcode_reg == 5'h03 && cmd_cnt_reg == 4'd2)
						begin
							o_settle_cycles <= settle_prod[23:0]; // [RULE_15]
							cmd_cnt_reg <= 4'd0;
						end
						else if (opcode_reg == `OP_SENSE_DRIVE && cmd_cnt_reg == 4'd1)
						begin
							// Slot seven offers the single drive status byte
							cmd_cnt_reg <= 4'd0;
							res_cnt_reg <= 3'd7;
							phase_reg <= PH_RES; // [RULE_11]
						end
						else if (cmd_cnt_reg == `CMD_BYTES - 4'd1) // [RULE_13]
						begin
							cmd_cnt_reg <= 4'd0;
							phase_reg <= PH_EXEC; // [RULE_12]
							o_exec_active <= 1'b1;
						end
					end
				end
				PH_EXEC:
				begin
					if (i_index && index_cnt_reg != `ID_MISS_INDEX)
						index_cnt_reg <= index_cnt_reg + 2'd1;
					// Only a found sector restarts the miss window, so a disk of other headers still times out
					if (i_header_valid && hdr_match)
						index_cnt_reg <= 2'd0;
					if (i_id_marker_seen)
						id_seen_reg <= 1'b1;
					if (index_cnt_reg == `ID_MISS_INDEX)
					begin
						if (id_seen_reg)
							error_status_one_reg[`ES1_NO_SECTOR] <= 1'b1; // [RULE_01]
						else
							error_status_one_reg[`ES1_ABSENT_ID] <= 1'b1; // [RULE_03]
					end
					if (i_header_valid && i_id_crc_fault && opcode_reg == `OP_READ_ID)
						error_status_one_reg[`ES1_NO_SECTOR] <= 1'b1; // [RULE_01]
					if (i_header_valid && cyl_differs)
					begin
						error_status_two_reg[`ES2_CYL_MISMATCH] <= 1'b1; // [RULE_06]
						if (i_hdr_cyl == `BAD_CYL)
							error_status_two_reg[`ES2_BAD_TRACK] <= 1'b1; // [RULE_07]
					end
					if (is_write && i_write_protect)
						error_status_one_reg[`ES1_WP_HIT] <= 1'b1; // [RULE_02]
					if (i_data_mark_timeout)
					begin
						error_status_one_reg[`ES1_ABSENT_ID] <= 1'b1; // [RULE_03]
						error_status_two_reg[`ES2_NO_DATA_MARK] <= 1'b1; // [RULE_10]
					end
					if (((opcode_reg == `OP_READ_DATA || is_scan) && i_deleted_marker_seen)
						|| (opcode_reg == `OP_READ_DEL && i_data_marker_seen))
						error_status_two_reg[`ES2_DELETED] <= 1'b1; // [RULE_04]
					if (i_data_crc_fault)
						error_status_two_reg[`ES2_DATA_CRC] <= 1'b1; // [RULE_05]
					if (is_scan && i_scan_equal)
						error_status_two_reg[`ES2_SCAN_EQUAL] <= 1'b1; // [RULE_08]
					if (is_scan && i_scan_met)
						scan_hit_any_reg <= 1'b1;
					if (i_sector_done)
					begin
						if (internal_target_reg[2] == last_sector_num_reg) // [RULE_19]
						begin
							if (both_sides_flag_reg && !o_head_select && (is_read || is_write || is_scan))
							begin
								o_head_select <= 1'b1; // [RULE_18]
								internal_target_reg[1] <= 8'h01;
								internal_target_reg[2] <= 8'h01;
							end
							else
							begin
								if (is_scan && !scan_hit_any_reg && !i_scan_met)
									error_status_two_reg[`ES2_SCAN_UNMET] <= 1'b1; // [RULE_09]
								phase_reg <= PH_RES; // [RULE_12]
								o_exec_active <= 1'b0;
							end
						end
						else
							internal_target_reg[2] <= internal_target_reg[2] + {6'h00, o_scan_step}; // [RULE_21]
					end
					if (error_status_one_reg[`ES1_NO_SECTOR] || index_cnt_reg == `ID_MISS_INDEX)
					begin
						phase_reg <= PH_RES;
						o_exec_active <= 1'b0;
					end
				end
				PH_RES:
				begin
					if (rd_edge && i_register_select_line) // [RULE_25]
					begin
						if (res_cnt_reg == `RES_BYTES - 3'd1 || res_cnt_reg == 3'd7) // [RULE_13]
						begin
							res_cnt_reg <= 3'd0;
							phase_reg <= PH_CMD;
						end
						else
							res_cnt_reg <= res_cnt_reg + 3'd1;
					end
				end
				default: phase_reg <= PH_CMD;
			endcase
		end
	end

endmodule

// >>> dv/floppy_cmd_assertions.sv
/* Port checker for the floppy command block.
 Sees top ports only; one clock, async low reset. */
`timescale 1ns/1ps
module floppy_cmd_checker #(
	parameter CLK_HZ = 20000000
)(
	input wire i_clk,
	input wire i_reset_n,
	input wire i_rd_n,
	input wire i_index,
	input wire i_header_valid,
	input wire i_data_mark_timeout,
	input wire i_sector_done,
	input wire o_data_oe,
	input wire o_exec_active,
	input wire o_sector_match,
	input wire o_drive_unit_sel_low,
	input wire o_drive_unit_sel_high,
	input wire [23:0] o_settle_cycles,
	input wire [23:0] o_release_cycles,
	input wire [23:0] o_step_cycles
);
// ----------
// Properties
// ----------
localparam int MS = CLK_HZ / 1000;
// An execution may end on any medium event, a cycle late at most
wire ev = i_sector_done | i_index | i_header_valid | i_data_mark_timeout;
default clocking cb @(posedge i_clk);
endclocking
default disable iff (!i_reset_n);
chk_oe_on_read: assert property ($fell(i_rd_n) |=> o_data_oe)
	else $error("no drive after read");
chk_oe_idle: assert property (i_rd_n && $past(i_rd_n) |-> !o_data_oe)
	else $error("drive without read");
chk_match_cause: assert property (o_sector_match |-> $past(i_header_valid))
	else $error("match without header");
chk_match_pulse: assert property (o_sector_match |=> !o_sector_match)
	else $error("match too long");
chk_exec_end: assert property ($fell(o_exec_active) |-> $past(ev) || $past(ev, 2))
	else $error("exec ended without cause");
chk_units_hold: assert property (o_exec_active && $past(o_exec_active)
	|-> $stable({o_drive_unit_sel_low, o_drive_unit_sel_high}))
	else $error("unit moved in exec");
chk_step_range: assert property (o_step_cycles <= 16 * MS && o_step_cycles % MS == 0)
	else $error("step out of range");
chk_release_range: assert property (o_release_cycles <= 240 * MS && o_release_cycles % (16 * MS) == 0)
	else $error("release out of range");
chk_settle_range: assert property (o_settle_cycles <= 254 * MS && o_settle_cycles % (2 * MS) == 0)
	else $error("settle out of range");
cov_exec: cover property ($rose(o_exec_active));
cov_match: cover property (o_sector_match);
cov_read: cover property ($fell(i_rd_n) ##1 o_data_oe);
endmodule
bind floppy_cmd_status_logic floppy_cmd_checker #(.CLK_HZ(CLK_HZ)) u_chk (.i_clk, .i_reset_n, .i_rd_n,
	.i_index, .i_header_valid, .i_data_mark_timeout, .i_sector_done, .o_data_oe, .o_exec_active,
	.o_sector_match, .o_drive_unit_sel_low, .o_drive_unit_sel_high, .o_settle_cycles, .o_release_cycles,
	.o_step_cycles);

// >>> dv/floppy_medium_model.sv
/* Medium partner: index, ID markers, headers, data markers.
 Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
module floppy_medium_model(
	input wire i_clk,
	output logic o_index = 1'h0,
	output logic o_id_mark = 1'h0,
	output logic o_hdr_valid = 1'h0,
	output logic [7:0] o_hdr_cyl = 8'h00,
	output logic [7:0] o_hdr_head = 8'h00,
	output logic [7:0] o_hdr_sector = 8'h00,
	output logic [7:0] o_hdr_size = 8'h00,
	output logic o_data_mark = 1'h0,
	output logic o_del_mark = 1'h0,
	output logic o_data_crc = 1'h0,
	output logic o_sector_done = 1'h0
);
// ----------
// Events
// ----------
task automatic index_pulse;
	@(posedge i_clk);
	o_index <= 1'h1;
	@(posedge i_clk);
	o_index <= 1'h0;
endtask
task automatic header(input [7:0] c, h, r, n);
	@(posedge i_clk);
	o_id_mark <= 1'h1;
	@(posedge i_clk);
	o_id_mark <= 1'h0;
	o_hdr_valid <= 1'h1;
	{o_hdr_cyl, o_hdr_head, o_hdr_sector, o_hdr_size} <= {c, h, r, n};
	@(posedge i_clk);
	o_hdr_valid <= 1'h0;
	// Fields are not held once valid drops, so show garbage
	{o_hdr_cyl, o_hdr_head, o_hdr_sector, o_hdr_size} <= ~{c, h, r, n};
endtask
task automatic data(input del, crc);
	repeat (2) @(posedge i_clk);
	o_data_mark <= !del;
	o_del_mark <= del;
	@(posedge i_clk);
	o_data_mark <= 1'h0;
	o_del_mark <= 1'h0;
	o_data_crc <= crc;
	o_sector_done <= 1'h1;
	@(posedge i_clk);
	o_data_crc <= 1'h0;
	o_sector_done <= 1'h0;
endtask
endmodule

// >>> dv/tb.sv
/* Self-checking bench: host strobes plus ID CRC, data-mark timeout and scan flags by hand, other medium events from the partner.
 Assumes the checker binds itself to the design. */
`timescale 1ns/1ps
module tb;
localparam int MS = 20000;
logic i_clk = 1'h0, i_reset_n = 1'h0, i_register_select_line = 1'h1, i_rd_n = 1'h1, i_wr_n = 1'h1;
logic i_write_protect = 1'h0, i_drive_fault_state = 1'h0, i_drive_ready_state = 1'h1;
logic i_track_zero_state = 1'h0, i_two_sided_state = 1'h1;
logic [7:0] i_data = 8'h00, v;
wire [7:0] o_data, hc, hh, hs, hn, o_target_sector, o_gap_three_len;
wire [23:0] o_settle_cycles, o_release_cycles, o_step_cycles;
wire [1:0] o_scan_step;
wire o_data_oe, o_exec_active, o_head_select, o_drive_unit_sel_low, o_drive_unit_sel_high;
wire o_density_select, o_sector_match, idx, idm, hv, dm, ddm, dcrc, sd;
logic idcrc = 1'h0, dto = 1'h0, sc_eq = 1'h0, sc_met = 1'h0;
int n_mismatch = 0, total_checks = 0, cycles = 0, n_match = 0;
floppy_medium_model med (.i_clk, .o_index(idx), .o_id_mark(idm), .o_hdr_valid(hv), .o_hdr_cyl(hc),
	.o_hdr_head(hh), .o_hdr_sector(hs), .o_hdr_size(hn), .o_data_mark(dm), .o_del_mark(ddm),
	.o_data_crc(dcrc), .o_sector_done(sd));
floppy_cmd_status_logic dut (.i_clk, .i_reset_n, .i_register_select_line, .i_rd_n, .i_wr_n, .i_data,
	.o_data, .o_data_oe, .i_drive_fault_state, .i_write_protect, .i_drive_ready_state, .i_track_zero_state,
	.i_two_sided_state, .i_index(idx), .i_id_marker_seen(idm), .i_header_valid(hv), .i_hdr_cyl(hc),
	.i_hdr_head(hh), .i_hdr_sector(hs), .i_hdr_size(hn), .i_id_crc_fault(idcrc), .i_data_marker_seen(dm),
	.i_deleted_marker_seen(ddm), .i_data_mark_timeout(dto), .i_data_crc_fault(dcrc), .i_sector_done(sd),
	.i_scan_equal(sc_eq), .i_scan_met(sc_met), .o_exec_active, .o_head_select, .o_drive_unit_sel_low,
	.o_drive_unit_sel_high, .o_density_select, .o_target_sector, .o_sector_match, .o_gap_three_len,
	.o_scan_step, .o_settle_cycles, .o_release_cycles, .o_step_cycles);
// ----------
// Host tasks
// ----------
initial forever #25 i_clk = ~i_clk;
task automatic finish_test;
	$display("checks %0d mismatches %0d", total_checks, n_mismatch);
	if (n_mismatch == 0 && total_checks > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
task automatic chk(input [23:0] got, exp);
	total_checks++;
	if (got !== exp)
	begin
		n_mismatch++;
		$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
	end
endtask
task automatic wr(input [7:0] b);
	@(posedge i_clk);
	i_wr_n <= 1'h0;
	i_data <= b;
	@(posedge i_clk);
	i_wr_n <= 1'h1;
endtask
task automatic rd(input sel, output [7:0] d);
	@(posedge i_clk);
	i_register_select_line <= sel;
	i_rd_n <= 1'h0;
	@(posedge i_clk);
	@(negedge i_clk);
	d = o_data;
	chk(o_data_oe, 1'h1);
	@(posedge i_clk);
	i_rd_n <= 1'h1;
	i_register_select_line <= 1'h1;
endtask
task automatic wait_exec(input lvl);
	for (int i = 0; i < 200 && o_exec_active !== lvl; i++)
		@(negedge i_clk);
	chk(o_exec_active, lvl);
endtask
task automatic cmd(input [7:0] op, hu, c, r, last_sector_num, lb);
	logic [7:0] b [9];
	b = '{op, hu, c, 8'h01, r, 8'h02, last_sector_num, 8'h1b, lb};
	foreach (b[i]) wr(b[i]);
endtask
task automatic res(input [7:0] s0, e1, e2, r);
	logic [7:0] e [7];
	e = '{s0, e1, e2, 8'h0a, 8'h01, r, 8'h02};
	for (int i = 0; i < 7; i++)
	begin
		rd(1'h1, v);
		chk(v, e[i]);
	end
	rd(1'h0, v);
	chk(v[7:6], 2'h2);
endtask
// ----------
// Scenarios
// ----------
task automatic t_specify(input [7:0] b1, b2, input int st, rl, se);
	wr(8'h03);
	wr(b1);
	wr(b2);
	repeat (2) @(posedge i_clk);
	chk(o_step_cycles, st * MS);
	chk(o_release_cycles, rl * MS);
	chk(o_settle_cycles, se * MS);
endtask
task automatic t_read;
	int m;
	rd(1'h0, v);
	chk(v[7:6], 2'h2);
	cmd(8'h46, 8'h05, 8'h0a, 8'h01, 8'h02, 8'hff);
	wait_exec(1'h1);
	chk({o_density_select, o_head_select, o_drive_unit_sel_high, o_drive_unit_sel_low}, 4'hd);
	chk({o_gap_three_len, o_target_sector}, 16'h1b01);
	m = n_match;
	med.header(8'h0a, 8'h01, 8'h01, 8'h02);
	med.data(1'h1, 1'h0);
	@(negedge i_clk);
	chk(o_exec_active, 1'h1);
	chk(24'(n_match - m), 24'h1);
	med.header(8'h0a, 8'h01, 8'h02, 8'h02);
	med.data(1'h0, 1'h1);
	wait_exec(1'h0);
	res(8'h05, 8'h00, 8'h60, 8'h02);
endtask
task automatic t_bad_cyl;
	int m;
	cmd(8'h06, 8'h05, 8'h0a, 8'h01, 8'h01, 8'hff);
	wait_exec(1'h1);
	chk(o_density_select, 1'h0);
	m = n_match;
	med.header(8'hff, 8'h01, 8'h01, 8'h02);
	repeat (2) med.index_pulse();
	wait_exec(1'h0);
	chk(24'(n_match - m), 24'h0);
	res(8'h05, 8'h04, 8'h12, 8'h01);
endtask
task automatic t_protect;
	i_write_protect <= 1'h1;
	cmd(8'h05, 8'h05, 8'h0a, 8'h01, 8'h01, 8'hff);
	med.header(8'h0a, 8'h01, 8'h01, 8'h02);
	med.data(1'h0, 1'h0);
	wait_exec(1'h0);
	res(8'h05, 8'h02, 8'h00, 8'h01);
	i_write_protect <= 1'h0;
endtask
task automatic t_read_id;
	cmd(8'h4a, 8'h05, 8'h0a, 8'h01, 8'h01, 8'hff);
	idcrc <= 1'h1;
	med.header(8'h0a, 8'h01, 8'h01, 8'h02);
	idcrc <= 1'h0;
	wait_exec(1'h0);
	res(8'h05, 8'h04, 8'h00, 8'h01);
endtask
task automatic t_scan(input met);
	cmd(8'h91, 8'h01, 8'h0a, 8'h01, 8'h03, 8'h02);
	wait_exec(1'h1);
	chk(o_scan_step, 2'h2);
	@(posedge i_clk);
	sc_eq <= 1'h1;
	sc_met <= met;
	dto <= 1'h1;
	@(posedge i_clk);
	sc_eq <= 1'h0;
	sc_met <= 1'h0;
	dto <= 1'h0;
	med.data(1'h0, 1'h0);
	repeat (2) @(negedge i_clk);
	chk(o_target_sector, 8'h03);
	med.data(1'h0, 1'h0);
	repeat (2) @(negedge i_clk);
	chk({o_head_select, o_target_sector}, 9'h101);
	med.data(1'h0, 1'h0);
	med.data(1'h0, 1'h0);
	wait_exec(1'h0);
	res(8'h05, 8'h01, met ? 8'h09 : 8'h0d, 8'h03);
endtask
task automatic t_sense;
	i_track_zero_state <= 1'h1;
	wr(8'h04);
	wr(8'h06);
	rd(1'h1, v);
	chk(v, 8'h3e);
	rd(1'h0, v);
	chk(v[7:6], 2'h2);
	i_track_zero_state <= 1'h0;
endtask
always @(posedge i_clk)
begin
	cycles++;
	if (o_sector_match === 1'h1)
		n_match++;
	if (cycles == 20000)
	begin
		n_mismatch++;
		finish_test;
	end
end
initial
begin
	repeat (6) @(posedge i_clk);
	i_reset_n <= 1'h1;
	@(negedge i_clk);
	chk({o_scan_step, o_exec_active, o_data_oe}, 4'h4);
	t_specify(8'hf2, 8'h06, 1, 32, 6);
	t_specify(8'he1, 8'hfe, 2, 16, 254);
	t_read;
	t_bad_cyl;
	t_protect;
	t_read_id;
	t_scan(1'h0);
	t_scan(1'h1);
	t_sense;
	finish_test;
end
endmodule
